// ---- half_bridge_input_decoder.sv ----
// Three-phase gate input decoder with dead time, fault flags and APB registers
`timescale 1ns/1ps
module half_bridge_input_decoder #(
  parameter int READY_CYCLES = hb_pkg::READY_CYC
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller pins
  input wire logic enable,
  input wire hb_pkg::gate_pair_t phase_in,
  input wire logic [5:0] gate_fb,
  // Serial pins
  input wire logic serial_select_n,
  input wire logic serial_sdo_d,
  output logic serial_sdo,
  output logic serial_sdo_oe_n,
  // Gate outputs
  output hb_pkg::gate_pair_t gate_out,
  output logic fault_flag_n,
  output logic irq
);
  import hb_pkg::*;

  // ==========================================================
  // Input synchronisers
  gate_pair_t in_s1_q, in_s2_q;
  logic [5:0] fb_s1_q, fb_s2_q;
  logic [1:0] en_sync_q, sel_sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      fb_s1_q <= 6'h00;
      fb_s2_q <= 6'h00;
      en_sync_q <= 2'h0;
      sel_sync_q <= 2'h3;
    end else begin
      in_s1_q <= phase_in;
      in_s2_q <= in_s1_q;
      fb_s1_q <= gate_fb;
      fb_s2_q <= fb_s1_q;
      en_sync_q <= {en_sync_q[0], enable};
      sel_sync_q <= {sel_sync_q[0], serial_select_n};
    end
  end
  wire en_s = en_sync_q[1];
  wire sel_n_s = sel_sync_q[1];

  // ==========================================================
  // Registers
  logic [2:0] mode_q;
  logic cfg_done_q;
  logic [2:0] stat_q, mask_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  run_state_t state_q;
  logic [31:0] rdy_cnt_q;
  wire bus_ready = (state_q != ST_BOOT);
  wire acc = psel && penable && pready_q;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STAT);
  wire hit_mask = (paddr == ADDR_MASK);
  wire hit_gate = (paddr == ADDR_GATE);
  wire hit_any = hit_ctrl || hit_stat || hit_mask || hit_gate;
  wire wr = acc && pwrite && bus_ready;
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) rd_mux = {28'h0, cfg_done_q, mode_q};
    else if (hit_stat) rd_mux = {29'h0, stat_q};
    else if (hit_mask) rd_mux = {29'h0, mask_q};
    else if (hit_gate) rd_mux = {26'h0, gate_out.hi, gate_out.lo};
    else rd_mux = 32'h0;
  end

  // Ready counter: bus answers with error until 1 ms after enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_BOOT;
      rdy_cnt_q <= 32'h0;
    end else if (!en_s) begin
      state_q <= ST_BOOT;
      rdy_cnt_q <= 32'h0;
    end else begin
      case (state_q)
        ST_BOOT: begin
          rdy_cnt_q <= rdy_cnt_q + 32'h1;
          if (rdy_cnt_q >= 32'(READY_CYCLES - 1)) state_q <= ST_CFG;
        end
        ST_CFG: begin
          if (cfg_done_q) state_q <= ST_RUN;
        end
        ST_RUN: begin
          // Clearing the done bit parks the gates again
          if (!cfg_done_q) state_q <= ST_CFG;
        end
        default: state_q <= ST_BOOT;
      endcase
    end
  end

  // APB slave: one wait state, answer on second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && (!hit_any || !bus_ready);
      prdata_q <= (psel && penable && !pready_q && !pwrite && bus_ready) ? rd_mux : 32'h0;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_6X;
      cfg_done_q <= 1'b0;
      mask_q <= FAULT_MASK_RST;
    end else begin
      if (wr && hit_ctrl) begin
        mode_q <= pwdata[CTRL_MODE_LSB +: 3];
        cfg_done_q <= pwdata[CTRL_CFG_DONE];
      end
      if (wr && hit_mask) mask_q <= pwdata[2:0];
      if (!en_s) cfg_done_q <= 1'b0;
    end
  end

  // ==========================================================
  // Decoding per phase
  logic [2:0] req_hi, req_lo, dead_bypass;
  logic [2:0] cnt_zero;
  logic [2:0] fault_ev;
  gate_pair_t gate_q;
  wire run = (state_q == ST_RUN);
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ph
      logic h, l;
      logic ind_fet;
      logic [7:0] dt_q;
      logic hi_q, lo_q;
      assign h = in_s2_q.hi[p];
      assign l = in_s2_q.lo[p];
      assign ind_fet = (mode_q == MODE_FET)
        || (mode_q == MODE_AB_HB && p == 2)
        || (mode_q == MODE_BC_HB && p == 0)
        || (mode_q == MODE_A_HB && p != 0);
      assign dead_bypass[p] = ind_fet;
      always_comb begin
        req_hi[p] = 1'b0;
        req_lo[p] = 1'b0;
        if (ind_fet) begin
          req_hi[p] = h;
          req_lo[p] = l;
        end else if (mode_q == MODE_6X) begin
          req_hi[p] = h && !l;
          req_lo[p] = l && !h;
        end else if (mode_q == MODE_1X) begin
          // Block tables are not implemented: phase held off
          req_hi[p] = 1'b0;
        end else begin
          // Three-input and independent half-bridge share one table
          req_hi[p] = l && h;
          req_lo[p] = l && !h;
        end
      end
      assign cnt_zero[p] = (dt_q == 8'h0);
      // Except in dead_bypass phases, a gate turns on only after the other gate has been off for the dead time
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dt_q <= 8'h0;
          hi_q <= 1'b0;
          lo_q <= 1'b0;
        end else if (!run) begin
          dt_q <= 8'(DEAD_CYC);
          hi_q <= 1'b0;
          lo_q <= 1'b0;
        end else if (dead_bypass[p]) begin
          dt_q <= 8'h0;
          hi_q <= req_hi[p];
          lo_q <= req_lo[p];
        end else begin
          hi_q <= req_hi[p] && !lo_q && cnt_zero[p];
          lo_q <= req_lo[p] && !hi_q && cnt_zero[p];
          if (hi_q && !req_hi[p] || lo_q && !req_lo[p]) dt_q <= 8'(DEAD_CYC);
          else if (!cnt_zero[p]) dt_q <= dt_q - 8'h1;
        end
      end
      assign gate_q.hi[p] = hi_q;
      assign gate_q.lo[p] = lo_q;
      // Feedback comes back through two sync flops, so it is compared with the
      // command as it stood two cycles ago; a bare compare flags every switching edge
      logic [1:0] hi_dly_q, lo_dly_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hi_dly_q <= 2'h0;
          lo_dly_q <= 2'h0;
        end else begin
          hi_dly_q <= {hi_dly_q[0], hi_q};
          lo_dly_q <= {lo_dly_q[0], lo_q};
        end
      end
      // Gate fault: feedback disagrees with command
      assign fault_ev[p] = run && ((fb_s2_q[p] != hi_dly_q[1]) || (fb_s2_q[p+3] != lo_dly_q[1]));
    end
  endgenerate
  assign gate_out = gate_q;

  // ==========================================================
  // Fault status, interrupt, serial output
  logic fault_n_q, irq_q, sdo_q, sdo_oe_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
      fault_n_q <= 1'b1;
      irq_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else begin
      // Set wins over write-one-to-clear
      stat_q <= (stat_q & ~((wr && hit_stat) ? pwdata[2:0] : 3'h0)) | fault_ev;
      fault_n_q <= ~|stat_q;
      irq_q <= |(stat_q & mask_q);
      sdo_q <= serial_sdo_d;
      sdo_oe_n_q <= sel_n_s;
    end
  end
  assign fault_flag_n = fault_n_q;
  assign irq = irq_q;
  assign serial_sdo = sdo_q;
  assign serial_sdo_oe_n = sdo_oe_n_q;

  // ==========================================================
  // Checks
  sequence both_on_s(int i);
    gate_out.hi[i] && gate_out.lo[i];
  endsequence
  sixin_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_6X && $stable(mode_q) && in_s2_q.hi[0] && !in_s2_q.lo[0] && cnt_zero[0] && !gate_out.lo[0]
    |=> gate_out.hi[0]) else $error("six-input high not driven");
  sixin_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_6X && in_s2_q.hi[1] == in_s2_q.lo[1] |=> !gate_out.hi[1] && !gate_out.lo[1])
    else $error("six-input both not off");
  threein_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_3X && !in_s2_q.lo[2] |=> !gate_out.hi[2] && !gate_out.lo[2])
    else $error("three-input low not off");
  threein_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_3X && !dead_bypass[0] |-> not both_on_s(0)) else $error("both gates on");
  fet_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_FET && $stable(mode_q) |=> gate_out.hi[0] == $past(in_s2_q.hi[0]))
    else $error("fet mode not following");
  dead_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && !dead_bypass[1] && $fell(gate_out.hi[1]) |-> !gate_out.lo[1] [*4])
    else $error("no dead time");
  gates_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> gate_out == '0) else $error("gates on before run");
  // Four samples: two sync flops and the output flop lie between pin and enable
  sdo_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_select_n [*4] |-> serial_sdo_oe_n) else $error("sdo not released");
  oe_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_select_n [*4] |-> !serial_sdo_oe_n) else $error("sdo not driven");
  dead_time_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && !dead_bypass[0] && $fell(gate_out.lo[0]) |-> !gate_out.hi[0] [*4]) else $error("no dead time low");
  hb_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dead_bypass[2] |-> not both_on_s(2)) else $error("half-bridge shoot-through");

  // ==========================================================
  // Status and bus checks
  sequence fault_flag_s;
    stat_q != 3'h0 ##1 !fault_flag_n;
  endsequence
  fault_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    |fault_ev |=> fault_flag_s) else $error("fault not flagged");
  fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    stat_q == 3'h0 |=> fault_flag_n) else $error("fault pin stuck low");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(stat_q & mask_q) |=> irq) else $error("interrupt not raised");
  irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stat_q & mask_q) == 3'h0 |=> !irq) else $error("interrupt without cause");
  stat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    stat_q[0] && !(wr && hit_stat && pwdata[0]) |=> stat_q[0]) else $error("status bit lost");
  ph0_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_ev[0] |=> stat_q[0]) else $error("phase A fault not latched");
  gate_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_ev[1] |=> stat_q[1]) else $error("phase B fault not latched");
  ph2_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_ev[2] |=> stat_q[2]) else $error("phase C fault not latched");
  boot_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !bus_ready |=> pslverr && prdata == 32'h0) else $error("early access accepted");
  boot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    en_s && state_q == ST_BOOT && rdy_cnt_q < 32'(READY_CYCLES - 1) |=> state_q == ST_BOOT)
    else $error("bus ready too soon");
  rdy_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    en_s && state_q == ST_BOOT && rdy_cnt_q >= 32'(READY_CYCLES - 1) |=> state_q == ST_CFG)
    else $error("bus never ready");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_done_q |=> !run) else $error("gates live before configuration");

  // ==========================================================
  // Mode table checks
  mode_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ctrl |=> mode_q == $past(pwdata[2:0]))
    else $error("mode not taken");
  onex_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_1X |=> gate_out == '0) else $error("block commutation drove a gate");
  ihb_table_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_IHB && !in_s2_q.lo[0] |=> !gate_out.hi[0] && !gate_out.lo[0])
    else $error("half-bridge not released");
  ab_fet_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_AB_HB && $stable(mode_q) |=> gate_out.lo[2] == $past(in_s2_q.lo[2]))
    else $error("phase C not following");
  bc_fet_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_BC_HB && $stable(mode_q) |=> gate_out.hi[0] == $past(in_s2_q.hi[0]))
    else $error("phase A not following");
  a_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_A_HB |-> not both_on_s(0)) else $error("phase A shoot-through");
  a_hb_fet_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_A_HB && $stable(mode_q) |=> gate_out.lo[1] == $past(in_s2_q.lo[1]))
    else $error("phase B not following");
  fet_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_FET && $stable(mode_q) |=> gate_out.lo[2] == $past(in_s2_q.lo[2]))
    else $error("fet low gate not following");
  sixin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_6X && $stable(mode_q) && !in_s2_q.hi[2] && in_s2_q.lo[2]
    && cnt_zero[2] && !gate_out.hi[2] |=> gate_out.lo[2]) else $error("six-input low not driven");
  sixin_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_6X |-> not both_on_s(2)) else $error("six-input shoot-through");
  threein_off0_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_3X && !in_s2_q.lo[0] |=> !gate_out.hi[0] && !gate_out.lo[0]) else $error("phase A not off");
  threein_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    run && mode_q == MODE_3X && $stable(mode_q) && in_s2_q.lo[1] && in_s2_q.hi[1]
    && cnt_zero[1] && !gate_out.lo[1] |=> gate_out.hi[1]) else $error("three-input high not driven");
endmodule : half_bridge_input_decoder

// ---- hb_pkg.sv ----
// Constants and types for the half-bridge input decoder
package hb_pkg;
  localparam logic [2:0] MODE_6X = 3'h0;
  localparam logic [2:0] MODE_3X = 3'h1;
  localparam logic [2:0] MODE_1X = 3'h2;
  localparam logic [2:0] MODE_IHB = 3'h3;
  localparam logic [2:0] MODE_AB_HB = 3'h4;
  localparam logic [2:0] MODE_BC_HB = 3'h5;
  localparam logic [2:0] MODE_A_HB = 3'h6;
  localparam logic [2:0] MODE_FET = 3'h7;
  localparam int CLK_MHZ = 40;
  localparam int READY_US = 1000;
  localparam int READY_CYC = READY_US * CLK_MHZ;
  localparam int DEAD_NS = 100;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_GATE = 12'h00c;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CFG_DONE = 3;
  localparam logic [2:0] FAULT_MASK_RST = 3'h7;
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } gate_pair_t;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_CFG = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;
endpackage : hb_pkg

// ---- hb_power_stage.sv ----
// Power stage model that echoes gate commands back as feedback
`timescale 1ns/1ps
module hb_power_stage
  import hb_pkg::*;
(
  // Gate side
  input wire hb_pkg::gate_pair_t gate_out,
  input wire logic [5:0] inject,
  // Feedback
  output logic [5:0] gate_fb
);
  // Ideal FETs follow at once; inject flips bits so a gate looks stuck
  assign gate_fb = {gate_out.lo, gate_out.hi} ^ inject;
endmodule : hb_power_stage

// ---- tb_half_bridge_input_decoder.sv ----
// Self-checking bench for the half-bridge input decoder
`timescale 1ns/1ps
module tb_half_bridge_input_decoder;
  import hb_pkg::*;
  // ==========================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_sdo, serial_sdo_oe_n, fault_flag_n, irq, err;
  logic enable = 1'b0;
  logic serial_select_n = 1'b1;
  gate_pair_t phase_in = '0;
  gate_pair_t gate_out;
  logic [5:0] gate_fb;
  logic [5:0] inject = 6'h00;
  logic [31:0] rd;
  int failures = 0;
  int samples_checked = 0;
  always #12.5 pclk = ~pclk;
  half_bridge_input_decoder #(.READY_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enable(enable), .phase_in(phase_in), .gate_fb(gate_fb),
    .serial_select_n(serial_select_n), .serial_sdo_d(1'b1), .serial_sdo(serial_sdo),
    .serial_sdo_oe_n(serial_sdo_oe_n), .gate_out(gate_out), .fault_flag_n(fault_flag_n), .irq(irq));
  hb_power_stage u_stage (.gate_out(gate_out), .inject(inject), .gate_fb(gate_fb));
  // ==========================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; print_verdict; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Covers two sync flops, the output register and the dead time
  task drive(input logic [2:0] h, input logic [2:0] l);
    @(posedge pclk);
    phase_in <= '{hi: h, lo: l};
    repeat (12) @(posedge pclk);
  endtask : drive
  task set_mode(input logic [2:0] m);
    drive(3'h0, 3'h0);
    apb(1'b1, ADDR_CTRL, 32'h8 | 32'(m));
  endtask : set_mode
  // ==========================================
  // Scenarios
  task t_boot;
    int n;
    chk(32'({gate_out, fault_flag_n, irq}), 32'h2);
    enable <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(32'(err), 32'h1);
    n = 0;
    do begin apb(1'b0, ADDR_CTRL, 32'h0); n++; end while (err !== 1'b0 && n < 20);
    if (err !== 1'b0) begin failures++; print_verdict; end
    chk(32'(err), 32'h0);
    drive(3'h7, 3'h0);
    chk(32'(gate_out), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    $display("boot test done");
  endtask : t_boot
  task t_tables(input logic three);
    logic [2:0] h, l;
    set_mode(three ? MODE_3X : MODE_6X);
    for (int i = 0; i < 8; i++) begin
      h = 3'(i);
      l = {h[0], h[2], h[1]};
      drive(h, l);
      if (three) chk(32'(gate_out), 32'({l & h, l & ~h}));
      else chk(32'(gate_out), 32'({h & ~l, l & ~h}));
    end
    $display("table test done");
  endtask : t_tables
  // Gates for inputs hi=101 lo=011 in each mode, from the mode tables
  task t_modes;
    logic [5:0] exp_g [8];
    exp_g = '{6'h22, 6'h0a, 6'h00, 6'h0a, 6'h2a, 6'h0b, 6'h2a, 6'h2b};
    for (int m = 0; m < 8; m++) begin
      set_mode(3'(m));
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd & 32'hf, 32'h8 | 32'(m));
      drive(3'h5, 3'h3);
      chk(32'(gate_out), 32'(exp_g[m]));
    end
    drive(3'h5, 3'h3);
    chk(32'(gate_out), 32'h2b);
    $display("mode test done");
  endtask : t_modes
  task t_fault;
    int n;
    set_mode(MODE_6X);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(rd & 32'h7, 32'(FAULT_MASK_RST));
    inject <= 6'h01;
    n = 0;
    do begin @(posedge pclk); n++; end while (fault_flag_n !== 1'b0 && n < 50);
    if (fault_flag_n !== 1'b0) begin failures++; print_verdict; end
    inject <= 6'h00;
    chk(32'({fault_flag_n, irq}), 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h7, 32'h1);
    apb(1'b1, ADDR_MASK, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, ADDR_STAT, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h7, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(fault_flag_n), 32'h1);
    $display("fault test done");
  endtask : t_fault
  task t_serial;
    serial_select_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'({serial_sdo_oe_n, serial_sdo}), 32'h1);
    serial_select_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(serial_sdo_oe_n), 32'h1);
    $display("serial test done");
  endtask : t_serial
  // ==========================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot;
    t_tables(1'b0);
    t_tables(1'b1);
    t_modes;
    t_fault;
    t_serial;
    print_verdict;
  end
endmodule : tb_half_bridge_input_decoder
